// [verilog/agcc_pkg.sv]
// Purpose: Constants for the stereo ADC volume, trim and AGC block
// Assumes: Register numbers are byte offsets on the device register port
// Notes: Gain values count half-decibel steps; levels use a log scale
package agcc_pkg;
  // Register offsets
  localparam logic [6:0] ADDR_STATUS = 7'h24;
  localparam logic [6:0] ADDR_NOISE = 7'h2f;
  localparam logic [6:0] ADDR_STEP = 7'h51;
  localparam logic [6:0] ADDR_TRIM = 7'h52;
  localparam logic [6:0] ADDR_VOL_L = 7'h53;
  localparam logic [6:0] ADDR_VOL_R = 7'h54;
  localparam logic [6:0] ADDR_AGC_L = 7'h56;
  localparam logic [6:0] ADDR_AGC_R = 7'h5e;
  localparam logic [6:0] ADDR_AGC_END = 7'h66;
  localparam logic [2:0] AGC_GAIN_IDX = 3'h7;
  // Values after reset
  localparam logic [6:0] RST_VOL = 7'h00;
  localparam logic [1:0] RST_STEP = 2'h0;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_AGC = 8'h00;
  localparam logic [6:0] RST_PGA = 7'h00;
  // Field positions
  localparam int STAT_VOL_L = 7;
  localparam int STAT_SAT_L = 5;
  localparam int STAT_VOL_R = 3;
  localparam int STAT_SAT_R = 1;
  localparam int NOISE_BIT_L = 6;
  localparam int NOISE_BIT_R = 5;
  // Soft-step modes (bit 1 set disables stepping)
  localparam logic [1:0] STEP_ONE = 2'h0;
  localparam logic [1:0] STEP_TWO = 2'h1;
  // Volume code limits and gain table layout
  localparam logic [6:0] VOL_MIN = 7'h68;
  localparam logic [6:0] VOL_MAX = 7'h28;
  localparam logic [6:0] VOL_BIAS = 7'h18;
  localparam logic [6:0] VOL_OCT = 7'h0c;
  localparam logic [6:0] PGA_MAX = 7'h50;
  localparam logic [3:0] TRIM_MAX = 4'h4;
  localparam logic [16:0] VOL_MANT [12] = '{17'h08000, 17'h0879c, 17'h08fad, 17'h09838,
    17'h0a145, 17'h0aadc, 17'h0b505, 17'h0bfc9, 17'h0cb30, 17'h0d745, 17'h0e412, 17'h0f1a2};
  localparam logic [15:0] TRIM_MULT [5] = '{16'h8000, 16'h7e87, 16'h7d12, 16'h7ba3, 16'h7a37};
  // Level detector and log-domain thresholds
  localparam int AVG_SHIFT = 5;
  localparam logic [8:0] LOG_FS = 9'h170;
  localparam logic [15:0] DB_TO_LOG = 16'h0055;
  localparam logic [15:0] THR_BASE = 16'h001c;
  localparam logic [8:0] HYST_LOG [4] = '{9'h002, 9'h005, 9'h007, 9'h000};
  localparam logic [15:0] TGT_HALF [8] = '{16'h000b, 16'h0010, 16'h0014, 16'h0018,
    16'h001c, 16'h0022, 16'h0028, 16'h0030};
  typedef enum logic {NS_SIGNAL, NS_NOISE} agcc_nstate_e;
endpackage : agcc_pkg

// [verilog/agcc_buf.sv]
// Purpose: Two-entry buffer on the output sample path
// Assumes: Source and sink share the core clock
// Notes: Ready and output data come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module agcc_buf #(
  parameter int WIDTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic [WIDTH-1:0] skid_reg;
  logic skid_empty_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_reg;

  assign o_in_ready = skid_empty_reg;
  assign o_out_valid = out_valid_reg;
  assign o_out_data = out_reg;

  // Head word moves on drain; second word parks while sink stalls
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      skid_reg <= '0;
      skid_empty_reg <= 1'b1;
      out_valid_reg <= 1'b0;
      out_reg <= '0;
    end
    else if (!out_valid_reg || i_out_ready)
    begin
      if (!skid_empty_reg)
      begin
        out_reg <= skid_reg;
        out_valid_reg <= 1'b1;
        skid_empty_reg <= 1'b1;
      end
      else
      begin
        out_reg <= i_in_data;
        out_valid_reg <= i_in_valid;
      end
    end
    else if (i_in_valid && skid_empty_reg)
    begin
      skid_reg <= i_in_data;
      skid_empty_reg <= 1'b0;
    end
  end
endmodule : agcc_buf
`default_nettype wire

// [verilog/agcc_level.sv]
// Purpose: Average of absolute sample value, reported on a log scale
// Assumes: One update per accepted sample
// Notes: Log unit is one sixteenth of an octave
`timescale 1ns/1ps
`default_nettype none
module agcc_level
  import agcc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_take,
  input wire logic [15:0] i_sample,
  output logic [8:0] o_level_log
);
  logic [23:0] avg_reg;
  logic [23:0] mag;
  logic [24:0] diff;
  logic [8:0] log_next;
  logic [23:0] norm;

  // Absolute value scaled so full scale sits at bit 23
  always_comb
  begin
    mag = {(i_sample[15] ? 16'(-i_sample) : i_sample), 8'h00};
    diff = {1'b0, mag} - {1'b0, avg_reg};
  end

  // Running average, not a peak hold
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      avg_reg <= '0;
    else if (i_take)
      avg_reg <= 24'($signed({1'b0, avg_reg}) + ($signed(diff) >>> AVG_SHIFT));
  end

  // Leading one plus four bits below it
  always_comb
  begin
    log_next = '0;
    norm = '0;
    for (int b = 0; b < 24; b++)
    begin
      if (avg_reg[b])
      begin
        norm = avg_reg << (23 - b);
        log_next = 9'(b * 16) + 9'(norm[22:19]);
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      o_level_log <= '0;
    else
      o_level_log <= log_next;
  end
endmodule : agcc_level
`default_nettype wire

// [verilog/agcc_top.sv]
// Purpose: Stereo ADC digital volume, fine trim and AGC of PGA gain
// Assumes: One sample period per accepted stereo sample pair
// Notes: Registers sit on a simple byte port at their device offsets
// Summary of operation
// - Per-channel volume, -12 to +20 dB, half-dB
// - Seven-bit twos-complement volume code, reset unity
// - Volume soft-steps one/two per sample, or jumps
// - Power-down ramps volume to minimum, then off
// - Status bits 7/3 show volume reached
// - Fine trim attenuation 0 to -0.4 dB
// - AGC steers PGA gain once per sample
// - Level is running average of magnitude
// - Eight target levels, -5.5 to -24 dBFS
// - Above target, lower gain at attack rate
// - Below target, raise gain at decay rate
// - Noise steps gain to unity, sets flag
// - Noise threshold -30 to -90 dB, can disable
// - AGC never raises gain past programmed ceiling; steps down if above
// - Hysteresis window around threshold, can disable
// - Noise after below-threshold debounce; no raising
// - Resume raising after signal debounce time
// - Noise flag readable; unity gain while set
// - Gain readback register shows applied AGC gain
// - PGA gain moves one step per one/two samples
// - Saturation flag when ceiling blocks target
`timescale 1ns/1ps
`default_nettype none
module agcc_top
  import agcc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_pwr_l,
  input wire logic i_pwr_r,
  input wire logic i_smp_valid,
  input wire logic [15:0] i_smp_l,
  input wire logic [15:0] i_smp_r,
  output logic o_smp_ready,
  output logic o_out_valid,
  output logic [15:0] o_out_l,
  output logic [15:0] o_out_r,
  input wire logic i_out_ready,
  output logic [6:0] o_pga_gain_l,
  output logic [6:0] o_pga_gain_r,
  output logic o_ch_on_l,
  output logic o_ch_on_r
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  logic [7:0] agc_cfg_reg [2][8];
  logic [6:0] vol_reg [2];
  logic [7:0] trim_reg;
  logic [1:0] step_reg;
  logic [6:0] app_vol_reg [2];
  logic [6:0] pga_reg [2];
  logic sat_reg [2];
  agcc_nstate_e nstate_reg [2];
  logic on_reg [2];
  logic pwr [2];
  logic [15:0] smp [2];
  logic [15:0] scaled [2];
  logic [8:0] lvl [2];
  logic take, agc_sel, agc_ch, rd_status;
  logic [2:0] agc_idx;
  logic [7:0] rd_mux;
  logic [31:0] out_word;

  assign take = i_smp_valid && o_smp_ready;
  assign pwr[0] = i_pwr_l;
  assign pwr[1] = i_pwr_r;
  assign smp[0] = i_smp_l;
  assign smp[1] = i_smp_r;
  assign o_out_l = out_word[31:16];
  assign o_out_r = out_word[15:0];
  assign o_pga_gain_l = pga_reg[0];
  assign o_pga_gain_r = pga_reg[1];
  assign o_ch_on_l = on_reg[0];
  assign o_ch_on_r = on_reg[1];
  assign rd_status = i_reg_rd && (i_reg_addr == ADDR_STATUS);

  // AGC register window decode
  always_comb
  begin
    agc_sel = (i_reg_addr >= ADDR_AGC_L) && (i_reg_addr < ADDR_AGC_END);
    agc_ch = (i_reg_addr >= ADDR_AGC_R);
    agc_idx = 3'(i_reg_addr - (agc_ch ? ADDR_AGC_R : ADDR_AGC_L));
  end

  // Writable configuration
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      vol_reg[0] <= RST_VOL;
      vol_reg[1] <= RST_VOL;
      trim_reg <= RST_TRIM;
      step_reg <= RST_STEP;
      for (int c = 0; c < 2; c++)
        for (int r = 0; r < 8; r++)
          agc_cfg_reg[c][r] <= RST_AGC;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == ADDR_VOL_L)
        vol_reg[0] <= i_reg_wdata[6:0];
      if (i_reg_addr == ADDR_VOL_R)
        vol_reg[1] <= i_reg_wdata[6:0];
      if (i_reg_addr == ADDR_TRIM)
        trim_reg <= i_reg_wdata;
      if (i_reg_addr == ADDR_STEP)
        step_reg <= i_reg_wdata[1:0];
      if (agc_sel && agc_idx != AGC_GAIN_IDX)
        agc_cfg_reg[agc_ch][agc_idx] <= i_reg_wdata;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (i_reg_addr == ADDR_STATUS)
    begin
      rd_mux[STAT_VOL_L] = (app_vol_reg[0] == vol_reg[0]);
      rd_mux[STAT_SAT_L] = sat_reg[0];
      rd_mux[STAT_VOL_R] = (app_vol_reg[1] == vol_reg[1]);
      rd_mux[STAT_SAT_R] = sat_reg[1];
    end
    else if (i_reg_addr == ADDR_NOISE)
    begin
      rd_mux[NOISE_BIT_L] = (nstate_reg[0] == NS_NOISE);
      rd_mux[NOISE_BIT_R] = (nstate_reg[1] == NS_NOISE);
    end
    else if (i_reg_addr == ADDR_STEP)
      rd_mux = {6'h00, step_reg};
    else if (i_reg_addr == ADDR_TRIM)
      rd_mux = trim_reg;
    else if (i_reg_addr == ADDR_VOL_L)
      rd_mux = {1'b0, vol_reg[0]};
    else if (i_reg_addr == ADDR_VOL_R)
      rd_mux = {1'b0, vol_reg[1]};
    else if (agc_sel && agc_idx == AGC_GAIN_IDX)
      rd_mux = {1'b0, pga_reg[agc_ch]};
    else if (agc_sel)
      rd_mux = agc_cfg_reg[agc_ch][agc_idx];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= rd_mux;
  end

  status_read_a: assert property (rd_status |=> o_reg_rdata[STAT_VOL_L] ==
    $past(app_vol_reg[0] == vol_reg[0])) else $error("left volume status wrong");

  // Independent per-channel volume, trim and AGC
  for (genvar ch = 0; ch < 2; ch++)
  begin : gen_ch
    logic [6:0] vol_tgt, u, idx, oct, max_g;
    logic [3:0] trim_sel;
    logic signed [33:0] p1, v1;
    logic signed [42:0] p2, v2;
    logic [7:0] c0, c1, c3, c4;
    logic [4:0] nd_cfg;
    logic [3:0] sd_cfg;
    logic [8:0] thr_u, hy_u, tgt_u;
    logic [15:0] thr_mul;
    logic thr_on, below, above, under_thr, slew_ok, agc_en;
    logic [4:0] nd_cnt_reg;
    logic [3:0] sd_cnt_reg;
    logic [7:0] atk_cnt_reg, dec_cnt_reg;
    logic phase_reg;

    // Signed half-dB code to mantissa and octave, then trim
    always_comb
    begin
      u = 7'(vol_reg[ch] == app_vol_reg[ch] ? app_vol_reg[ch] + VOL_BIAS
                                           : app_vol_reg[ch] + VOL_BIAS);
      idx = u % VOL_OCT;
      oct = u / VOL_OCT;
      trim_sel = (ch == 0) ? trim_reg[7:4] : trim_reg[3:0];
      if (trim_sel > TRIM_MAX)
        trim_sel = TRIM_MAX;
      p1 = $signed(smp[ch]) * $signed({1'b0, VOL_MANT[idx[3:0]]});
      v1 = p1 >>> (7'd17 - oct);
      p2 = $signed(v1[25:0]) * $signed({1'b0, TRIM_MULT[trim_sel[2:0]]});
      v2 = p2 >>> 15;
      if (v2 > 43'sd32767)
        scaled[ch] = 16'h7fff;
      else if (v2 < -43'sd32768)
        scaled[ch] = 16'h8000;
      else
        scaled[ch] = v2[15:0];
    end

    // Applied volume walks toward its target once per sample
    always_comb
      vol_tgt = pwr[ch] ? vol_reg[ch] : VOL_MIN;

    always_ff @(posedge i_core_clk)
    begin
      if (!i_rst_n)
        app_vol_reg[ch] <= RST_VOL;
      else if (take && app_vol_reg[ch] != vol_tgt)
      begin
        if (step_reg[1])
          app_vol_reg[ch] <= vol_tgt;
        else if ($signed(vol_tgt) > $signed(app_vol_reg[ch]))
          app_vol_reg[ch] <= (step_reg == STEP_TWO &&
            $signed(vol_tgt) > $signed(7'(app_vol_reg[ch] + 7'h01))) ?
            7'(app_vol_reg[ch] + 7'h02) : 7'(app_vol_reg[ch] + 7'h01);
        else
          app_vol_reg[ch] <= (step_reg == STEP_TWO &&
            $signed(vol_tgt) < $signed(7'(app_vol_reg[ch] - 7'h01))) ?
            7'(app_vol_reg[ch] - 7'h02) : 7'(app_vol_reg[ch] - 7'h01);
      end
    end

    // Channel shuts off only once the ramp has reached minimum
    always_ff @(posedge i_core_clk)
    begin
      if (!i_rst_n)
        on_reg[ch] <= 1'b0;
      else if (pwr[ch])
        on_reg[ch] <= 1'b1;
      else if (app_vol_reg[ch] == VOL_MIN)
        on_reg[ch] <= 1'b0;
    end

    agcc_level u_level (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_take(take),
      .i_sample(smp[ch]),
      .o_level_log(lvl[ch])
    );

    // Configuration fields and log-domain comparisons
    always_comb
    begin
      c0 = agc_cfg_reg[ch][0];
      c1 = agc_cfg_reg[ch][1];
      c3 = agc_cfg_reg[ch][3];
      c4 = agc_cfg_reg[ch][4];
      nd_cfg = agc_cfg_reg[ch][5][4:0];
      sd_cfg = agc_cfg_reg[ch][6][3:0];
      agc_en = c0[7];
      max_g = (agc_cfg_reg[ch][2][6:0] > PGA_MAX) ? PGA_MAX : agc_cfg_reg[ch][2][6:0];
      tgt_u = LOG_FS - 9'((TGT_HALF[c0[6:4]] * DB_TO_LOG) >> 6);
      thr_on = (c1[5:1] != 5'h00);
      thr_mul = (THR_BASE + 16'(c1[5:1]) * 16'h0002) * DB_TO_LOG;
      thr_u = LOG_FS - 9'(thr_mul >> 5);
      hy_u = HYST_LOG[c1[7:6]];
      below = ({1'b0, lvl[ch]} + {1'b0, hy_u}) < {1'b0, thr_u};
      above = {1'b0, lvl[ch]} > ({1'b0, thr_u} + {1'b0, hy_u});
      under_thr = thr_on && (lvl[ch] < thr_u);
      slew_ok = (step_reg != STEP_TWO) || phase_reg;
    end

    // Noise and signal classification with debounce
    always_ff @(posedge i_core_clk)
    begin
      if (!i_rst_n)
      begin
        nstate_reg[ch] <= NS_SIGNAL;
        nd_cnt_reg <= '0;
        sd_cnt_reg <= '0;
      end
      else if (take)
      begin
        if (!thr_on || !agc_en)
        begin
          nstate_reg[ch] <= NS_SIGNAL;
          nd_cnt_reg <= '0;
          sd_cnt_reg <= '0;
        end
        else if (nstate_reg[ch] == NS_SIGNAL)
        begin
          sd_cnt_reg <= '0;
          if (!below)
            nd_cnt_reg <= '0;
          else if (nd_cnt_reg >= nd_cfg)
          begin
            nstate_reg[ch] <= NS_NOISE;
            nd_cnt_reg <= '0;
          end
          else
            nd_cnt_reg <= 5'(nd_cnt_reg + 5'h01);
        end
        else
        begin
          if (!above)
            sd_cnt_reg <= '0;
          else if (sd_cnt_reg >= sd_cfg)
          begin
            nstate_reg[ch] <= NS_SIGNAL;
            sd_cnt_reg <= '0;
          end
          else
            sd_cnt_reg <= 4'(sd_cnt_reg + 4'h1);
        end
      end
    end

    // PGA gain update once per sample
    always_ff @(posedge i_core_clk)
    begin
      if (!i_rst_n)
      begin
        pga_reg[ch] <= RST_PGA;
        atk_cnt_reg <= '0;
        dec_cnt_reg <= '0;
        phase_reg <= 1'b0;
      end
      else if (take)
      begin
        phase_reg <= ~phase_reg;
        if (!agc_en || nstate_reg[ch] == NS_NOISE || pga_reg[ch] > max_g)
        begin
          atk_cnt_reg <= '0;
          dec_cnt_reg <= '0;
          if (slew_ok && pga_reg[ch] != 7'h00)
            pga_reg[ch] <= 7'(pga_reg[ch] - 7'h01);
        end
        else if (lvl[ch] > tgt_u)
        begin
          dec_cnt_reg <= '0;
          if (atk_cnt_reg < c3)
            atk_cnt_reg <= 8'(atk_cnt_reg + 8'h01);
          else if (slew_ok)
          begin
            atk_cnt_reg <= '0;
            if (pga_reg[ch] != 7'h00)
              pga_reg[ch] <= 7'(pga_reg[ch] - 7'h01);
          end
        end
        else if (lvl[ch] < tgt_u && !under_thr)
        begin
          atk_cnt_reg <= '0;
          if (dec_cnt_reg < c4)
            dec_cnt_reg <= 8'(dec_cnt_reg + 8'h01);
          else if (slew_ok)
          begin
            dec_cnt_reg <= '0;
            if (pga_reg[ch] < max_g)
              pga_reg[ch] <= 7'(pga_reg[ch] + 7'h01);
          end
        end
        else
        begin
          atk_cnt_reg <= '0;
          dec_cnt_reg <= '0;
        end
      end
    end

    // Sticky saturation; a new event wins over clear-on-read
    always_ff @(posedge i_core_clk)
    begin
      if (!i_rst_n)
        sat_reg[ch] <= 1'b0;
      else if (take && agc_en && nstate_reg[ch] == NS_SIGNAL && lvl[ch] < tgt_u &&
               !under_thr && pga_reg[ch] >= max_g)
        sat_reg[ch] <= 1'b1;
      else if (rd_status)
        sat_reg[ch] <= 1'b0;
    end

    vol_range_a: assert property ($signed(app_vol_reg[ch]) >= -7'sd24 &&
      $signed(app_vol_reg[ch]) <= 7'sd40) else $error("volume out of range");
    vol_step_a: assert property (take && step_reg == STEP_ONE |=>
      app_vol_reg[ch] - $past(app_vol_reg[ch]) inside {7'h00, 7'h01, 7'h7f})
      else $error("volume moved more than one step");
    vol_jump_a: assert property (take && step_reg[1] |=>
      app_vol_reg[ch] == $past(vol_tgt)) else $error("volume did not jump");
    shut_off_a: assert property ($fell(on_reg[ch]) |-> $past(app_vol_reg[ch]) == VOL_MIN)
      else $error("channel off before ramp done");
    pga_slew_a: assert property (pga_reg[ch] != $past(pga_reg[ch]) |->
      $past(take) && (pga_reg[ch] - $past(pga_reg[ch]) inside {7'h01, 7'h7f}))
      else $error("pga moved more than one step");
    pga_cap_a: assert property (take && pga_reg[ch] >= max_g |=>
      pga_reg[ch] <= $past(pga_reg[ch])) else $error("pga raised past ceiling");
    noise_unity_a: assert property (take && nstate_reg[ch] == NS_NOISE &&
      step_reg != STEP_TWO && pga_reg[ch] != 7'h00 |=>
      pga_reg[ch] == 7'($past(pga_reg[ch]) - 7'h01)) else $error("noise not toward unity");
    sat_set_a: assert property (take && agc_en && nstate_reg[ch] == NS_SIGNAL &&
      lvl[ch] < tgt_u && !under_thr && pga_reg[ch] >= max_g |=> sat_reg[ch])
      else $error("saturation flag missed");
  end

  // Scaled stereo word into the two-entry buffer
  agcc_buf #(
    .WIDTH(32)
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_smp_valid),
    .i_in_data({scaled[0], scaled[1]}),
    .o_in_ready(o_smp_ready),
    .o_out_valid(o_out_valid),
    .o_out_data(out_word),
    .i_out_ready(i_out_ready)
  );
endmodule : agcc_top
`default_nettype wire

// [dv/agcc_src.sv]
// Purpose: Analog front end model that feeds ADC sample pairs
// Assumes: The microphone path feeds both channels
// Notes: Holds each pair until taken; fresh values while idle
`timescale 1ns/1ps
`default_nettype none
module agcc_src (
  input wire logic i_core_clk,
  input wire logic i_en,
  input wire logic [15:0] i_amp,
  input wire logic i_ready,
  output logic o_valid,
  output logic [15:0] o_l,
  output logic [15:0] o_r
);
  logic took = 1'b0;
  initial o_valid = 1'b0;
  // Note just before the edge whether the pair on the pins is taken
  always @(negedge i_core_clk)
  begin
    #4;
    took = o_valid && i_ready;
  end
  // New pair only after the old one is taken; microphone path only
  always @(negedge i_core_clk)
  begin
    if (took || !o_valid)
    begin
      o_valid = i_en && ($urandom_range(3) != 0);
      o_l = 16'($urandom_range(32'(i_amp) * 2) - 32'(i_amp));
      o_r = 16'($urandom_range(32'(i_amp) * 2) - 32'(i_amp));
    end
  end
endmodule : agcc_src
`default_nettype wire

// [dv/test_adc_gain_and_agc_control.sv]
// Purpose: Self-checking bench for volume, trim and AGC control
// Assumes: Volume code 0x0c doubles the sample exactly
// Notes: Output pairs are compared only while the gain is steady
`timescale 1ns/1ps
`default_nettype none
module test_adc_gain_and_agc_control
  import agcc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ordy = 1'b0;
  logic pwr_l = 1'b1, pwr_r = 1'b1, en = 1'b0, stall = 1'b0, cmp_on = 1'b0;
  logic [6:0] addr = 7'h00, pga_l, pga_r, max_l = 7'h50;
  logic [7:0] wdata = 8'h00, rdata;
  logic [15:0] amp = 16'h0fff, sl, sr, ol, out_r;
  logic sv, srdy, ov, on_l, on_r;
  logic tk = 1'b0;
  logic [1:0] vsh = 2'h0;
  logic [32:0] expq[$], e;
  int num_errors = 0, total_checks = 0;

  agcc_top dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_pwr_l(pwr_l),
    .i_pwr_r(pwr_r), .i_smp_valid(sv), .i_smp_l(sl), .i_smp_r(sr), .o_smp_ready(srdy),
    .o_out_valid(ov), .o_out_l(ol), .o_out_r(out_r), .i_out_ready(ordy),
    .o_pga_gain_l(pga_l), .o_pga_gain_r(pga_r), .o_ch_on_l(on_l), .o_ch_on_r(on_r));
  agcc_src src_u (.i_core_clk(clk), .i_en(en), .i_amp(amp), .i_ready(srdy),
    .o_valid(sv), .o_l(sl), .o_r(sr));

  // 100 MHz clock
  always #5 clk = ~clk;
  // Sink readiness, random or stalled
  always @(negedge clk) ordy = !stall && ($urandom_range(3) != 0);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [6:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(32'(rdata), 32'(x));
  endtask : rd_reg

  task automatic wait_smp(input int n);
    repeat (n) @(posedge clk iff tk);
    @(negedge clk);
  endtask : wait_smp

  // Reference model: sampled 1 ns before each rising edge, where all is settled
  always @(negedge clk)
  begin
    #4;
    tk = sv && srdy;
    if (tk)
      expq.push_back({cmp_on, 16'(sl << vsh), 16'(sr << vsh)});
    if (ov && ordy)
    begin
      e = expq.pop_front();
      if (e[32])
        chk({ol, out_r}, e[31:0]);
    end
    if (pga_l > max_l)
      chk(32'(pga_l), 32'(max_l));
  end

  // Hang guard
  initial
  begin
    #300000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(57289));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd_reg(ADDR_VOL_L, 8'h00);
    rd_reg(ADDR_STATUS, 8'h88);
    wr_reg(ADDR_STATUS, 8'hff);
    rd_reg(ADDR_STATUS, 8'h88);
    rd_reg(7'h10, 8'h00);
    wr_reg(ADDR_TRIM, 8'h42);
    rd_reg(ADDR_TRIM, 8'h42);
    wr_reg(ADDR_TRIM, 8'h00);
    // Jump mode, +6 dB on both channels
    wr_reg(ADDR_STEP, 8'h02);
    wr_reg(ADDR_VOL_L, VOL_OCT);
    wr_reg(ADDR_VOL_R, VOL_OCT);
    en = 1'b1;
    wait_smp(4);
    rd_reg(ADDR_STATUS, 8'h88);
    vsh = 2'h1;
    cmp_on = 1'b1;
    wait_smp(40);
    // Sink stall fills the buffer without loss
    stall = 1'b1;
    repeat (10) @(negedge clk);
    chk(32'(srdy), 32'h0);
    chk(32'(ov), 32'h1);
    stall = 1'b0;
    wait_smp(20);
    // One step per sample toward the maximum code
    cmp_on = 1'b0;
    wr_reg(ADDR_STEP, 8'h00);
    wr_reg(ADDR_VOL_L, VOL_MAX);
    wait_smp(2);
    rd_reg(ADDR_STATUS, 8'h08);
    wait_smp(40);
    rd_reg(ADDR_STATUS, 8'h88);
    // Power down ramps 64 steps before the channel turns off
    chk(32'(on_l), 32'h1);
    pwr_l = 1'b0;
    wait_smp(50);
    chk(32'(on_l), 32'h1);
    wait_smp(30);
    chk(32'(on_l), 32'h0);
    chk(32'(on_r), 32'h1);
    pwr_l = 1'b1;
    wait_smp(80);
    // AGC with a low ceiling and a faint input
    amp = 16'h0004;
    max_l = 7'h0a;
    wr_reg(ADDR_AGC_L + 7'h2, 8'h0a);
    wr_reg(ADDR_AGC_L + 7'h3, 8'h00);
    wr_reg(ADDR_AGC_L + 7'h4, 8'h00);
    wr_reg(ADDR_AGC_L + 7'h1, 8'h00);
    wr_reg(ADDR_AGC_L, 8'hf0);
    wait_smp(60);
    chk(32'(pga_l), 32'ha);
    chk(32'(pga_r), 32'h0);
    rd_reg(ADDR_AGC_L + 7'h7, 8'h0a);
    rd_reg(ADDR_STATUS, 8'ha8);
    // Loud input pulls the gain back down
    amp = 16'h7000;
    wait_smp(120);
    chk(32'(pga_l), 32'h0);
    amp = 16'h0004;
    wait_smp(150);
    chk(32'(pga_l), 32'ha);
    // Threshold -30 dB with 1 dB window; gain returns to unity
    wr_reg(ADDR_AGC_L + 7'h1, 8'h02);
    wait_smp(60);
    chk(32'(pga_l), 32'h0);
    rd_reg(ADDR_NOISE, 8'h40);
    wrap_up();
  end
endmodule : test_adc_gain_and_agc_control
`default_nettype wire
